// ### common/vdl_pkg.sv
// Package: level codes, channel map, register map and carrier types of the vertical driver level mapper
package vdl_pkg;

  // ==========================================================================
  // Level codes and carriers
  // ==========================================================================
  typedef enum logic [1:0] {
    VDL_LEVEL_LOW = 2'h0,
    VDL_LEVEL_MID = 2'h1,
    VDL_LEVEL_HIGH = 2'h2,
    VDL_LEVEL_LOWEST = 2'h3
  } vdl_level_type;

  localparam int VDL_NCH = 13;
  // Index order: 1,2,3,4,5a,5b,6,7a,7b,8,9,11,12
  typedef vdl_level_type [VDL_NCH-1:0] vdl_drive_type;

  typedef struct packed {
    logic [12:0] timing_vclock;
    logic [7:0] sensor_gate_pulse;
    logic internal_substrate_clock;
    logic precision_extra_pulse;
    logic field_start;
    logic field_gate_trigger;
  } vdl_tg_type;

  typedef struct packed {
    logic [3:0] general_shutter_pulse;
    logic [1:0] bias_pulse;
  } vdl_shut_type;

  typedef struct packed {
    logic mech_shutter_out;
    logic strobe_out;
    logic ccd_bias_select_out;
  } vdl_shout_type;

  // ==========================================================================
  // Channel map: vertical clock index, gate index, three-level flag
  // ==========================================================================
  localparam logic [VDL_NCH-1:0][3:0] VDL_CH_VCLK =
    {4'hb, 4'ha, 4'h8, 4'h7, 4'h6, 4'h6, 4'h5, 4'h4, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam logic [VDL_NCH-1:0][2:0] VDL_CH_GATE =
    {3'h3, 3'h1, 3'h0, 3'h0, 3'h7, 3'h6, 3'h0, 3'h5, 3'h4, 3'h0, 3'h2, 3'h0, 3'h0};
  localparam logic [VDL_NCH-1:0] VDL_CH_THREE = 13'h19b5;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int VDL_AW = 8;
  localparam logic [VDL_AW-1:0] VDL_OFF_CTRL = 8'h00;
  localparam logic [VDL_AW-1:0] VDL_OFF_ROUTE = 8'h04;
  localparam logic [VDL_AW-1:0] VDL_OFF_EXPOSURE = 8'h08;
  localparam logic [VDL_AW-1:0] VDL_OFF_STATUS = 8'h0c;

  // CTRL fields
  localparam int VDL_CTRL_SEL_LSB = 0;
  localparam int VDL_CTRL_KIND_LSB = 5;
  localparam int VDL_CTRL_TRIG_BIT = 7;
  // ROUTE fields, one 4-bit source code per shutter output
  localparam int VDL_ROUTE_MECH_LSB = 0;
  localparam int VDL_ROUTE_STROBE_LSB = 4;
  localparam int VDL_ROUTE_BIAS_LSB = 8;
  // STATUS fields
  localparam int VDL_ST_EN_BIT = 0;
  localparam int VDL_ST_SUB_LSB = 1;
  localparam int VDL_ST_ARMED_BIT = 3;
  localparam int VDL_ST_BUSY_BIT = 4;
  localparam int VDL_ST_BADSEL_BIT = 5;
  localparam int VDL_ST_COUNT_LSB = 16;

  localparam int VDL_EXP_W = 12;

  // Shutter kinds
  localparam logic [1:0] VDL_KIND_NORMAL = 2'h0;
  localparam logic [1:0] VDL_KIND_PRECISION = 2'h1;
  localparam logic [1:0] VDL_KIND_LOW_SPEED = 2'h2;

  // Substrate level-control selector codes
  localparam logic [4:0] VDL_SEL_INVALID = 5'h1d;
  localparam logic [4:0] VDL_SEL_HIGH = 5'h1e;
  localparam logic [4:0] VDL_SEL_LOW = 5'h1f;

  // Shutter route source codes
  localparam logic [3:0] VDL_SRC_GENERAL_SHUTTER_PULSE_0 = 4'h0;
  localparam logic [3:0] VDL_SRC_GENERAL_SHUTTER_PULSE_1 = 4'h1;
  localparam logic [3:0] VDL_SRC_GENERAL_SHUTTER_PULSE_2 = 4'h2;
  localparam logic [3:0] VDL_SRC_GENERAL_SHUTTER_PULSE_3 = 4'h3;
  localparam logic [3:0] VDL_SRC_BIAS0 = 4'h4;
  localparam logic [3:0] VDL_SRC_BIAS1 = 4'h5;
  localparam logic [3:0] VDL_SRC_S0_X_B0 = 4'h6;
  localparam logic [3:0] VDL_SRC_S0_X_B1 = 4'h7;
  localparam logic [3:0] VDL_SRC_S0_X_S1 = 4'h8;
  localparam logic [3:0] VDL_SRC_S0_X_S2 = 4'h9;

  // Reset values
  localparam logic [4:0] VDL_RST_SEL = VDL_SEL_LOW;
  localparam logic [1:0] VDL_RST_KIND = VDL_KIND_NORMAL;
  localparam logic [11:0] VDL_RST_ROUTE = 12'hfff;
  localparam logic [VDL_EXP_W-1:0] VDL_RST_EXPOSURE = 12'h000;

endpackage : vdl_pkg

// ### core/vdl_chan.sv
// One vertical drive channel: maps clock and gate inputs to a registered level code
`timescale 1ns/1ps
`default_nettype none
module vdl_chan #(
  parameter bit THREE_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Drive inputs
  input wire logic enable,
  input wire logic vclock,
  input wire logic gate,
  // Level code
  output vdl_pkg::vdl_level_type level
);
  import vdl_pkg::*;

  typedef struct packed {
    vdl_level_type level;
  } vdl_chan_state_type;

  vdl_chan_state_type state_reg;
  vdl_chan_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (!enable) begin
      state_next.level = VDL_LEVEL_MID; // [RL2] [RL3]
    end else if (vclock) begin
      state_next.level = VDL_LEVEL_LOW; // [RL4] [RL8]
    end else if (THREE_LEVEL && !gate) begin
      state_next.level = VDL_LEVEL_HIGH; // [RL1] [RL4]
    end else begin
      state_next.level = VDL_LEVEL_MID; // [RL4] [RL8]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{level: VDL_LEVEL_MID};
    end else begin
      state_reg <= state_next; // [RL15]
    end
  end

  assign level = state_reg.level;
endmodule : vdl_chan
`default_nettype wire

// ### core/vdl_shut_route.sv
// Shutter router: picks a plain or XOR-combined pulse for each of the three shutter outputs
`timescale 1ns/1ps
`default_nettype none
module vdl_shut_route (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pulses and selection
  input wire vdl_pkg::vdl_shut_type shut,
  input wire logic [11:0] route,
  // Shutter outputs
  output vdl_pkg::vdl_shout_type shout
);
  import vdl_pkg::*;

  typedef struct packed {
    vdl_shout_type shout;
  } vdl_route_state_type;

  vdl_route_state_type state_reg;
  vdl_route_state_type state_next;

  function automatic logic pick(input logic [3:0] code, input vdl_shut_type s);
    logic [3:0] g;
    logic [1:0] b;
    g = s.general_shutter_pulse;
    b = s.bias_pulse;
    unique case (code)
      VDL_SRC_GENERAL_SHUTTER_PULSE_0: pick = g[0]; // [RL11]
      VDL_SRC_GENERAL_SHUTTER_PULSE_1: pick = g[1];
      VDL_SRC_GENERAL_SHUTTER_PULSE_2: pick = g[2];
      VDL_SRC_GENERAL_SHUTTER_PULSE_3: pick = g[3];
      VDL_SRC_BIAS0: pick = b[0];
      VDL_SRC_BIAS1: pick = b[1];
      VDL_SRC_S0_X_B0: pick = g[0] ^ b[0]; // [RL12]
      VDL_SRC_S0_X_B1: pick = g[0] ^ b[1]; // [RL12]
      VDL_SRC_S0_X_S1: pick = g[0] ^ g[1]; // [RL12]
      VDL_SRC_S0_X_S2: pick = g[0] ^ g[2]; // [RL12]
      default: pick = 1'b0;
    endcase
  endfunction : pick

  always_comb begin
    state_next = state_reg;
    state_next.shout.mech_shutter_out = pick(route[VDL_ROUTE_MECH_LSB +: 4], shut); // [RL10]
    state_next.shout.strobe_out = pick(route[VDL_ROUTE_STROBE_LSB +: 4], shut); // [RL10]
    state_next.shout.ccd_bias_select_out = pick(route[VDL_ROUTE_BIAS_LSB +: 4], shut); // [RL10]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign shout = state_reg.shout;
endmodule : vdl_shut_route
`default_nettype wire

// ### core/vdl_top.sv
// Vertical driver level mapper: channel levels, substrate clock stage, shutter routing, APB registers
//
// How it works
// (RL1) With the enable pin high, each channel's level comes from its vertical clock and, on three-level channels, its gate pulse.
// (RL2) With the enable pin low, every channel shows mid and the substrate output shows its lowest level.
// (RL3) The enable pin overrides every vertical clock and gate input whatever their states.
// (RL4) Three-level channels give high for clock low gate low, mid for clock low gate high, low for clock high.
// (RL5) Channels 1 and 3 use their own clock and gate; 5a and 5b share clock 5 with gates 5 and 6.
// (RL6) Channels 7a and 7b share clock 7 with gates 7 and 8.
// (RL7) Channel 11 pairs clock 11 with gate 2, channel 12 pairs clock 12 with gate 4, three-level.
// (RL8) Two-level channels 2, 4, 6, 8 and 9 give mid for clock low and low for clock high.
// (RL9) Normal, high precision and low speed shutter kinds all act through the substrate clock pulse.
// (RL10) Mechanical shutter, strobe and bias select outputs are programmable.
// (RL11) Four shutter pulses and two bias pulses may each be routed to any of the three shutter outputs.
// (RL12) Shutter pulse 0 may be XORed with bias 0, bias 1, shutter 1 or shutter 2.
// (RL13) The substrate stage chooses among three levels from the substrate pulse and a level-control signal.
// (RL14) A 5-bit selector picks the level-control source; code 29 is invalid.
// (RL15) Each channel level is a registered two-bit code updated on the clock.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module vdl_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vdl_pkg::VDL_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timing generator side
  input wire logic vdrive_enable_pin,
  input wire vdl_pkg::vdl_tg_type tg,
  input wire vdl_pkg::vdl_shut_type shut,
  // Driver side
  output vdl_pkg::vdl_drive_type drive,
  output vdl_pkg::vdl_level_type substrate_clock_out,
  output vdl_pkg::vdl_shout_type shout
);
  import vdl_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [4:0] substrate_ctrl_select;
    logic [1:0] kind;
    logic [11:0] route;
    logic [VDL_EXP_W-1:0] exposure;
    logic [VDL_EXP_W-1:0] exp_count;
    logic armed;
    vdl_level_type sub_level;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } vdl_top_state_type;

  vdl_top_state_type state_reg;
  vdl_top_state_type state_next;

  logic substrate_level_ctrl;
  logic sub_pulse;
  logic bad_select;
  logic setup;
  logic wr;
  logic mapped;
  logic trig_wr;

  // ==========================================================================
  // Vertical channels
  // ==========================================================================
  genvar ch;
  generate
    for (ch = 0; ch < VDL_NCH; ch++) begin : g_chan
      vdl_chan #(
        .THREE_LEVEL(VDL_CH_THREE[ch])
      ) u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .enable(vdrive_enable_pin), // [RL3]
        .vclock(tg.timing_vclock[VDL_CH_VCLK[ch]]), // [RL5] [RL6] [RL7]
        .gate(tg.sensor_gate_pulse[VDL_CH_GATE[ch]]), // [RL5] [RL6] [RL7]
        .level(drive[ch])
      );
    end
  endgenerate

  // ==========================================================================
  // Shutter outputs
  // ==========================================================================
  vdl_shut_route u_route (
    .pclk(pclk),
    .presetn(presetn),
    .shut(shut),
    .route(state_reg.route), // [RL11]
    .shout(shout)
  );

  // ==========================================================================
  // Substrate level-control selector
  // ==========================================================================
  function automatic logic ctrl_src(input logic [4:0] code, input vdl_tg_type t,
                                    input vdl_shout_type o, input vdl_shut_type s);
    logic [12:0] v;
    logic [7:0] g;
    v = t.timing_vclock;
    g = t.sensor_gate_pulse;
    unique case (code)
      5'h00: ctrl_src = v[5];
      5'h01: ctrl_src = v[7];
      5'h02: ctrl_src = v[8];
      5'h03: ctrl_src = v[9];
      5'h04: ctrl_src = g[4];
      5'h05: ctrl_src = g[5];
      5'h06: ctrl_src = g[6];
      5'h07: ctrl_src = g[7];
      5'h08: ctrl_src = g[1];
      5'h09: ctrl_src = g[2];
      5'h0a: ctrl_src = g[3];
      5'h0b: ctrl_src = g[0];
      5'h0c: ctrl_src = v[12];
      5'h0d: ctrl_src = o.ccd_bias_select_out;
      5'h0e: ctrl_src = o.mech_shutter_out;
      5'h0f: ctrl_src = o.strobe_out;
      5'h10: ctrl_src = v[0];
      5'h11: ctrl_src = v[1];
      5'h12: ctrl_src = v[2];
      5'h13: ctrl_src = v[3];
      5'h14: ctrl_src = v[4];
      5'h15: ctrl_src = v[6];
      5'h16: ctrl_src = v[10];
      5'h17: ctrl_src = v[11];
      5'h18: ctrl_src = s.general_shutter_pulse[0];
      5'h19: ctrl_src = s.general_shutter_pulse[1];
      5'h1a: ctrl_src = s.general_shutter_pulse[2];
      5'h1b: ctrl_src = s.general_shutter_pulse[3];
      5'h1c: ctrl_src = t.field_gate_trigger;
      VDL_SEL_HIGH: ctrl_src = 1'b1;
      default: ctrl_src = 1'b0;
    endcase
  endfunction : ctrl_src

  always_comb begin
    substrate_level_ctrl = ctrl_src(state_reg.substrate_ctrl_select, tg, shout, shut); // [RL14]
    bad_select = (state_reg.substrate_ctrl_select == VDL_SEL_INVALID); // [RL14]
  end

  // ==========================================================================
  // Substrate pulse per shutter kind
  // ==========================================================================
  always_comb begin
    unique case (state_reg.kind)
      VDL_KIND_PRECISION: sub_pulse = tg.internal_substrate_clock | tg.precision_extra_pulse; // [RL9]
      VDL_KIND_LOW_SPEED: sub_pulse = tg.internal_substrate_clock & (state_reg.exp_count == '0); // [RL9]
      default: sub_pulse = tg.internal_substrate_clock; // [RL9]
    endcase
  end

  // ==========================================================================
  // APB decode
  // ==========================================================================
  always_comb begin
    setup = psel & ~penable;
    wr = psel & penable & pwrite & state_reg.pready;
    mapped = (paddr == VDL_OFF_CTRL) | (paddr == VDL_OFF_ROUTE) |
             (paddr == VDL_OFF_EXPOSURE) | (paddr == VDL_OFF_STATUS);
    trig_wr = wr & (paddr == VDL_OFF_CTRL) & pwdata[VDL_CTRL_TRIG_BIT];
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_next = state_reg;

    // Register writes
    if (wr) begin
      unique case (paddr)
        VDL_OFF_CTRL: begin
          state_next.substrate_ctrl_select = pwdata[VDL_CTRL_SEL_LSB +: 5];
          state_next.kind = pwdata[VDL_CTRL_KIND_LSB +: 2];
        end
        VDL_OFF_ROUTE: begin
          state_next.route = pwdata[11:0]; // [RL11]
        end
        VDL_OFF_EXPOSURE: begin
          state_next.exposure = pwdata[VDL_EXP_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Low speed exposure: arm on trigger, load at next field start, count fields
    if (tg.field_start) begin
      if (state_reg.armed) begin
        state_next.exp_count = state_reg.exposure; // [RL9]
        state_next.armed = 1'b0;
      end else if (state_reg.exp_count != '0) begin
        state_next.exp_count = state_reg.exp_count - 1'b1;
      end
    end
    if (trig_wr) begin
      state_next.armed = 1'b1;
    end

    // Substrate stage level
    if (!vdrive_enable_pin) begin
      state_next.sub_level = VDL_LEVEL_LOWEST; // [RL2] [RL3]
    end else if (sub_pulse) begin
      state_next.sub_level = VDL_LEVEL_HIGH; // [RL13]
    end else if (substrate_level_ctrl) begin
      state_next.sub_level = VDL_LEVEL_MID; // [RL13]
    end else begin
      state_next.sub_level = VDL_LEVEL_LOWEST; // [RL13]
    end

    // APB answer, loaded in the setup cycle
    state_next.pready = setup;
    state_next.pslverr = setup & ~mapped;
    state_next.prdata = '0;
    if (setup) begin
      unique case (paddr)
        VDL_OFF_CTRL: begin
          state_next.prdata[VDL_CTRL_SEL_LSB +: 5] = state_reg.substrate_ctrl_select;
          state_next.prdata[VDL_CTRL_KIND_LSB +: 2] = state_reg.kind;
        end
        VDL_OFF_ROUTE: begin
          state_next.prdata[11:0] = state_reg.route;
        end
        VDL_OFF_EXPOSURE: begin
          state_next.prdata[VDL_EXP_W-1:0] = state_reg.exposure;
        end
        VDL_OFF_STATUS: begin
          state_next.prdata[VDL_ST_EN_BIT] = vdrive_enable_pin;
          state_next.prdata[VDL_ST_SUB_LSB +: 2] = state_reg.sub_level;
          state_next.prdata[VDL_ST_ARMED_BIT] = state_reg.armed;
          state_next.prdata[VDL_ST_BUSY_BIT] = (state_reg.exp_count != '0);
          state_next.prdata[VDL_ST_BADSEL_BIT] = bad_select;
          state_next.prdata[VDL_ST_COUNT_LSB +: VDL_EXP_W] = state_reg.exp_count;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{
        substrate_ctrl_select: VDL_RST_SEL,
        kind: VDL_RST_KIND,
        route: VDL_RST_ROUTE,
        exposure: VDL_RST_EXPOSURE,
        exp_count: '0,
        armed: 1'b0,
        sub_level: VDL_LEVEL_LOWEST,
        prdata: '0,
        pready: 1'b0,
        pslverr: 1'b0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign substrate_clock_out = state_reg.sub_level;
endmodule : vdl_top
`default_nettype wire

// ### verif/vdl_ccd_model.sv
// Sensor seen through its high-voltage buffers: counts charge clears
`timescale 1ns/1ps
`default_nettype none
module vdl_ccd_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Driver side
  input wire vdl_pkg::vdl_drive_type drive,
  input wire vdl_pkg::vdl_level_type substrate_clock_out,
  // Observations
  output logic [15:0] clear_count,
  output logic level_fault
);
  import vdl_pkg::*;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_count <= 16'h0;
      level_fault <= 1'b0;
    end else begin
      if (substrate_clock_out == VDL_LEVEL_HIGH) clear_count <= clear_count + 16'h1;
      for (int i = 0; i < VDL_NCH; i++) if (drive[i] == VDL_LEVEL_LOWEST) level_fault <= 1'b1;
    end
  end
endmodule : vdl_ccd_model
`default_nettype wire

// ### verif/vdl_ref.svh
// Reference map from clock and gate inputs to channel level codes
function automatic vdl_pkg::vdl_drive_type vdl_ref_drive(input logic en, input logic [12:0] vc,
                                                        input logic [7:0] sg);
  int vi[13] = '{0, 1, 2, 3, 4, 4, 5, 6, 6, 7, 8, 10, 11};
  int gi[13] = '{0, -1, 2, -1, 4, 5, -1, 6, 7, -1, -1, 1, 3};
  vdl_pkg::vdl_drive_type d;
  for (int i = 0; i < 13; i++) begin
    if (!en) d[i] = vdl_pkg::VDL_LEVEL_MID;
    else if (vc[vi[i]]) d[i] = vdl_pkg::VDL_LEVEL_LOW;
    else if (gi[i] < 0 || sg[gi[i]]) d[i] = vdl_pkg::VDL_LEVEL_MID;
    else d[i] = vdl_pkg::VDL_LEVEL_HIGH;
  end
  return d;
endfunction : vdl_ref_drive

// ### verif/vdl_top_chk.sv
// Concurrent checks on the ports of the level mapper
`timescale 1ns/1ps
`default_nettype none
module vdl_top_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vdl_pkg::VDL_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timing generator side
  input wire logic vdrive_enable_pin,
  input wire vdl_pkg::vdl_tg_type tg,
  input wire vdl_pkg::vdl_shut_type shut,
  // Driver side
  input wire vdl_pkg::vdl_drive_type drive,
  input wire vdl_pkg::vdl_level_type substrate_clock_out,
  input wire vdl_pkg::vdl_shout_type shout
);
  import vdl_pkg::*;
  `include "vdl_ref.svh"
  logic up_reg;
  // ====
  // Helper: one edge seen since reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_reg <= 1'b0;
    else up_reg <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  // ====
  // Assertions
  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood too long");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_drive_map: assert property (up_reg |-> drive == vdl_ref_drive($past(vdrive_enable_pin),
      $past(tg.timing_vclock), $past(tg.sensor_gate_pulse)))
    else $error("channel level wrong");
  a_off_forces: assert property (up_reg && !$past(vdrive_enable_pin) |->
      substrate_clock_out == VDL_LEVEL_LOWEST && drive == {VDL_NCH{VDL_LEVEL_MID}})
    else $error("enable low not forcing");
  a_sub_no_low: assert property (substrate_clock_out != VDL_LEVEL_LOW)
    else $error("substrate shows low");
  a_two_level: assert property (drive[1] inside {VDL_LEVEL_MID, VDL_LEVEL_LOW})
    else $error("two-level channel off range");
endmodule : vdl_top_chk
bind vdl_top vdl_top_chk vdl_top_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .vdrive_enable_pin(vdrive_enable_pin), .tg(tg), .shut(shut), .drive(drive),
  .substrate_clock_out(substrate_clock_out), .shout(shout));
`default_nettype wire

// ### verif/vdl_top_tb.sv
// Self-checking bench of the level mapper
`timescale 1ns/1ps
`default_nettype none
module vdl_top_tb;
  import vdl_pkg::*;
  `include "vdl_ref.svh"
  typedef struct packed {logic [25:0] d; logic [1:0] s; vdl_shout_type o;} vdl_lnote_type;
  typedef struct packed {logic [31:0] d; logic e; logic r;} vdl_rnote_type;
  localparam vdl_tg_type TG_FS = 25'h2;
  localparam vdl_tg_type TG_PULSE = 25'h8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, en, fault, supp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] clears, cl0;
  logic [11:0] route;
  logic [4:0] sel;
  logic [1:0] kind;
  logic [4:0] sels[5] = '{5'h10, 5'h0b, 5'h1e, 5'h1d, 5'h1f};
  vdl_tg_type tg;
  vdl_shut_type shut;
  vdl_drive_type drive;
  vdl_level_type sub;
  vdl_shout_type shout;
  int failures, n_checks;
  vdl_lnote_type q_lvl[$];
  vdl_rnote_type q_rd[$];
  vdl_lnote_type ln;
  vdl_rnote_type rn;
  vdl_top vdl_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vdrive_enable_pin(en), .tg(tg), .shut(shut), .drive(drive), .substrate_clock_out(sub), .shout(shout));
  vdl_ccd_model vdl_ccd_model_inst (.pclk(pclk), .presetn(presetn), .drive(drive),
    .substrate_clock_out(sub), .clear_count(clears), .level_fault(fault));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ====
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  function automatic logic src(input logic [3:0] c, input vdl_shut_type s);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: return s.general_shutter_pulse[c[1:0]];
      4'h4, 4'h5: return s.bias_pulse[c[0]];
      4'h6: return s.general_shutter_pulse[0] ^ s.bias_pulse[0];
      4'h7: return s.general_shutter_pulse[0] ^ s.bias_pulse[1];
      4'h8: return s.general_shutter_pulse[0] ^ s.general_shutter_pulse[1];
      4'h9: return s.general_shutter_pulse[0] ^ s.general_shutter_pulse[2];
      default: return 1'b0;
    endcase
  endfunction : src
  function automatic vdl_level_type sub_exp(input logic e, input vdl_tg_type t);
    logic c;
    c = (sel == 5'h10) ? t.timing_vclock[0] : (sel == 5'h0b) ? t.sensor_gate_pulse[0] : (sel == 5'h1e);
    if (!e) return VDL_LEVEL_LOWEST;
    if ((t.internal_substrate_clock || (kind == VDL_KIND_PRECISION && t.precision_extra_pulse)) && !supp)
      return VDL_LEVEL_HIGH;
    return c ? VDL_LEVEL_MID : VDL_LEVEL_LOWEST;
  endfunction : sub_exp
  // ====
  // Drivers
  task automatic step(input logic e, input vdl_tg_type t, input vdl_shut_type s);
    en <= e;
    tg <= t;
    shut <= s;
    @(posedge pclk);
    q_lvl.push_back('{vdl_ref_drive(e, t.timing_vclock, t.sensor_gate_pulse), sub_exp(e, t),
      {src(route[3:0], s), src(route[7:4], s), src(route[11:8], s)}});
  endtask : step
  task automatic rnd(input int n);
    vdl_tg_type t;
    for (int i = 0; i < n; i++) begin
      t = 25'($urandom);
      t.field_start = 1'b0;
      step($urandom_range(3) != 0, t, vdl_shut_type'(6'($urandom)));
    end
  endtask : rnd
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ed,
                     input logic ee);
    int n;
    q_rd.push_back('{ed, ee, !w});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // ====
  // Monitors
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && q_rd.size() > 0) begin
      rn = q_rd.pop_front();
      if (rn.r) check(prdata, rn.d);
      check(pslverr, rn.e);
    end
  end
  always @(negedge pclk) begin
    while (q_lvl.size() > 0) begin
      ln = q_lvl.pop_front();
      check(drive, ln.d);
      check(sub, ln.s);
      check(shout, ln.o);
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end
  // ====
  // Scenarios
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, en, tg, shut, supp, kind} = '0;
    route = 12'hfff;
    sel = 5'h1f;
    failures = 0;
    n_checks = 0;
    void'($urandom(32'hd1902dc8));
    repeat (11) @(posedge pclk);
    @(negedge pclk);
    check(drive, {VDL_NCH{VDL_LEVEL_MID}});
    check(sub, VDL_LEVEL_LOWEST);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, VDL_OFF_CTRL, 32'h0, 32'h1f, 1'b0);
    apb(1'b0, VDL_OFF_ROUTE, 32'h0, 32'hfff, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'h5, 32'h0, 1'b1);
    apb(1'b1, VDL_OFF_STATUS, 32'hffffffff, 32'h0, 1'b0);
    for (int m = 0; m < 8; m++) step(m[2], {{13{m[0]}}, {8{m[1]}}, 4'h0}, '0);
    for (int i = 0; i < 5; i++) begin
      sel = sels[i];
      apb(1'b1, VDL_OFF_CTRL, {27'h0, sel}, 32'h0, 1'b0);
      rnd(40);
      step(1'b1, '0, '0);
      apb(1'b0, VDL_OFF_STATUS, 32'h0,
        {26'h0, sel == VDL_SEL_INVALID, 2'h0, sub_exp(1'b1, '0), 1'b1}, 1'b0);
    end
    for (int c = 0; c < 16; c++) begin
      route = {4'(c), 4'(15 - c), 4'(c)};
      apb(1'b1, VDL_OFF_ROUTE, {20'h0, route}, 32'h0, 1'b0);
      rnd(8);
    end
    apb(1'b0, VDL_OFF_ROUTE, 32'h0, {20'h0, route}, 1'b0);
    kind = VDL_KIND_PRECISION;
    apb(1'b1, VDL_OFF_CTRL, {25'h0, kind, sel}, 32'h0, 1'b0);
    rnd(30);
    kind = VDL_KIND_LOW_SPEED;
    apb(1'b1, VDL_OFF_EXPOSURE, 32'h2, 32'h0, 1'b0);
    apb(1'b1, VDL_OFF_CTRL, {24'h0, 1'b1, kind, sel}, 32'h0, 1'b0);
    step(1'b1, '0, '0);
    step(1'b1, '0, '0);
    apb(1'b0, VDL_OFF_STATUS, 32'h0, 32'hf, 1'b0);
    cl0 = clears;
    for (int k = 0; k < 3; k++) begin
      step(1'b1, TG_FS, '0);
      supp = (k != 2);
      step(1'b1, '0, '0);
      step(1'b1, TG_PULSE, '0);
      step(1'b1, '0, '0);
    end
    apb(1'b0, VDL_OFF_STATUS, 32'h0, 32'h7, 1'b0);
    check(32'(clears - cl0), 32'h1);
    check(fault, 1'b0);
    wrap_up();
  end
endmodule : vdl_top_tb
`default_nettype wire
